// >>> hdl/pwm_timer_out.sv
`default_nettype none
module pwm_timer_out (
   input  wire logic        REF_CLK,
   input  wire logic        SYS_RST,
   input  wire logic        SUB_OSC_CLK,
   input  wire logic        STOP_MODE,
   input  wire logic [11:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [11:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output logic             PULSE_OUT_PIN,
   output logic             PERIOD_IRQ
);
   ////////////////////////////////////////////////////////////////////////
   logic [11:0] aw_addr_q;
   logic        aw_have_q;
   logic        aw_rdy_q;
   logic        w_rdy_q;
   logic        ar_rdy_q;
   logic [7:0]  w_data_q;
   logic        w_strb_q;
   logic        w_have_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [1:0]  rresp_q;
   logic [31:0] rdata_q;
   logic        wr_fire;
   logic        rd_fire;
   logic        wr_ok;
   logic [7:0]  channel_ctrl_reg_q;
   logic [7:0]  duty_hold_q;
   logic [7:0]  duty_compare_reg_q;
   logic [7:0]  mask_q;
   logic [7:0]  stat_q;
   logic [7:0]  stat_d;
   logic [7:0]  cnt_q;
   logic [10:0] div_q;
   logic        sub_q;
   logic [2:0]  sub_div_q;
   logic        sub_rise;
   logic        sub8_tick;
   logic        tick;
   logic        run;
   logic        match;
   logic        ovf;
   logic        output_toggle_flop;
   logic        pin_q;
   logic        irq_q;
   logic        ctrl_wr;
   logic        duty_wr;
   logic        stat_wr;
   logic        mask_wr;

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   function automatic logic known_addr(input logic [11:0] a);
      known_addr = (a == pwm_pkg::OFS_CTRL) || (a == pwm_pkg::OFS_DUTY) ||
                   (a == pwm_pkg::OFS_STAT) || (a == pwm_pkg::OFS_MASK) ||
                   (a == pwm_pkg::OFS_COUNT);
   endfunction : known_addr

   // All-ones low bits of the divider
   function automatic logic div_tap(input logic [10:0] d, input int n);
      div_tap = ((d & ((11'h001 << n) - 11'h001)) ==
                 ((11'h001 << n) - 11'h001));
   endfunction : div_tap

   ////////////////////////////////////////////////////////////////////////
   // AXI write channel
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign wr_ok   = known_addr(aw_addr_q) && aw_addr_q != pwm_pkg::OFS_COUNT;
   assign ctrl_wr = wr_fire && w_strb_q && aw_addr_q == pwm_pkg::OFS_CTRL;
   assign duty_wr = wr_fire && w_strb_q && aw_addr_q == pwm_pkg::OFS_DUTY;
   assign stat_wr = wr_fire && w_strb_q && aw_addr_q == pwm_pkg::OFS_STAT;
   assign mask_wr = wr_fire && w_strb_q && aw_addr_q == pwm_pkg::OFS_MASK;

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         aw_have_q <= 1'b0;
         aw_rdy_q  <= 1'b1;
         aw_addr_q <= 12'h000;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_have_q <= 1'b1;
         aw_rdy_q  <= 1'b0;
         aw_addr_q <= S_AXI_AWADDR;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
         aw_rdy_q  <= 1'b1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         w_have_q <= 1'b0;
         w_rdy_q  <= 1'b1;
         w_data_q <= 8'h00;
         w_strb_q <= 1'b0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_have_q <= 1'b1;
         w_rdy_q  <= 1'b0;
         w_data_q <= S_AXI_WDATA[7:0];
         w_strb_q <= S_AXI_WSTRB[0];
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
         w_rdy_q  <= 1'b1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         bvalid_q <= 1'b0;
         bresp_q  <= pwm_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_ok ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   assign S_AXI_AWREADY = aw_rdy_q;
   assign S_AXI_WREADY  = w_rdy_q;
   assign S_AXI_BVALID  = bvalid_q;
   assign S_AXI_BRESP   = bresp_q;

   ////////////////////////////////////////////////////////////////////////
   // AXI read channel
   assign rd_fire = S_AXI_ARVALID && !rvalid_q;

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         rvalid_q <= 1'b0;
         ar_rdy_q <= 1'b1;
         rresp_q  <= pwm_pkg::RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end else if (rd_fire) begin
         rvalid_q <= 1'b1;
         ar_rdy_q <= 1'b0;
         rresp_q  <= known_addr(S_AXI_ARADDR) ? pwm_pkg::RESP_OKAY
                                              : pwm_pkg::RESP_SLVERR;
         unique case (S_AXI_ARADDR)
            pwm_pkg::OFS_CTRL:  rdata_q <= {24'h000000, channel_ctrl_reg_q};
            pwm_pkg::OFS_DUTY:  rdata_q <= {24'h000000, duty_hold_q};
            pwm_pkg::OFS_STAT:  rdata_q <= {24'h000000, stat_q};
            pwm_pkg::OFS_MASK:  rdata_q <= {24'h000000, mask_q};
            pwm_pkg::OFS_COUNT: rdata_q <= {24'h000000, cnt_q};
            default:            rdata_q <= 32'h0000_0000;
         endcase
      end else if (S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
         ar_rdy_q <= 1'b1;
      end
   end

   assign S_AXI_ARREADY = ar_rdy_q;
   assign S_AXI_RVALID  = rvalid_q;
   assign S_AXI_RRESP   = rresp_q;
   assign S_AXI_RDATA   = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Control, duty and mask registers
   assign run = channel_ctrl_reg_q[pwm_pkg::RUN_BIT];

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         channel_ctrl_reg_q <= pwm_pkg::CTRL_RST;
      end else if (ctrl_wr) begin
         channel_ctrl_reg_q <= w_data_q;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         mask_q <= 8'h00;
      end else if (mask_wr) begin
         mask_q <= w_data_q;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         duty_hold_q <= pwm_pkg::DUTY_RST;
      end else if (duty_wr) begin
         duty_hold_q <= w_data_q;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         duty_compare_reg_q <= pwm_pkg::DUTY_RST;
      end else if (duty_wr && !run) begin
         duty_compare_reg_q <= w_data_q;
      end else if (ovf) begin
         duty_compare_reg_q <= duty_hold_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Source clock selection
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         div_q     <= 11'h000;
         sub_q     <= 1'b0;
         sub_div_q <= 3'h0;
      end else begin
         div_q <= div_q + 11'h001;
         sub_q <= SUB_OSC_CLK;
         if (sub_rise) begin
            sub_div_q <= sub_div_q + 3'h1;
         end
      end
   end

   assign sub_rise  = SUB_OSC_CLK && !sub_q;
   assign sub8_tick = sub_rise && sub_div_q == pwm_pkg::SUB_DIV_MAX;

   always_comb begin
      unique case (pwm_pkg::pwm_src_e'(
                   channel_ctrl_reg_q[pwm_pkg::SRC_MSB:pwm_pkg::SRC_LSB]))
         pwm_pkg::SRC_DIV2K:  tick = channel_ctrl_reg_q[pwm_pkg::TAP_BIT]
                                     ? sub8_tick : div_tap(div_q, 11);
         pwm_pkg::SRC_DIV128: tick = div_tap(div_q, 7);
         pwm_pkg::SRC_DIV32:  tick = div_tap(div_q, 5);
         pwm_pkg::SRC_DIV8:   tick = div_tap(div_q, 3);
         pwm_pkg::SRC_SUB:    tick = sub_rise;
         pwm_pkg::SRC_DIV2:   tick = div_tap(div_q, 1);
         pwm_pkg::SRC_MAIN:   tick = 1'b1;
         pwm_pkg::SRC_NONE:   tick = 1'b0;
      endcase
      tick = tick && run && !STOP_MODE;
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter, compare and output flop
   assign match = tick && cnt_q == duty_compare_reg_q;
   assign ovf   = tick && cnt_q == pwm_pkg::CNT_MAX;
   assign output_toggle_flop = !pin_q;

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         cnt_q <= 8'h00;
      end else if (ovf) begin
         cnt_q <= 8'h00;
      end else if (tick) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         pin_q <= 1'b1;
      end else if (ctrl_wr && !run) begin
         pin_q <= !w_data_q[pwm_pkg::PRESET_BIT];
      end else if (match ^ ovf) begin
         pin_q <= !pin_q;
      end
   end

   assign PULSE_OUT_PIN = pin_q;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status and output
   always_comb begin
      stat_d = stat_q;
      if (stat_wr) begin
         stat_d = stat_d & ~w_data_q;
      end
      if (ovf) begin
         stat_d[pwm_pkg::IRQ_BIT] = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         stat_q <= 8'h00;
         irq_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         irq_q  <= |(stat_d & (mask_wr ? w_data_q : mask_q));
      end
   end

   assign PERIOD_IRQ = irq_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);

   sequence s_overflow;
      tick && cnt_q == 8'hFF;
   endsequence

   sequence s_mid_match;
      tick && cnt_q == duty_compare_reg_q && cnt_q != 8'hFF;
   endsequence

   cnt_advance_a: assert property (
      tick && cnt_q != 8'hFF |=> cnt_q == $past(cnt_q) + 8'h01)
      else $error("counter did not advance");
   ovf_clear_a: assert property (
      s_overflow |=> cnt_q == 8'h00)
      else $error("counter not cleared on overflow");
   match_toggle_a: assert property (
      s_mid_match |=> PULSE_OUT_PIN != $past(PULSE_OUT_PIN))
      else $error("match did not invert output");
   ovf_irq_a: assert property (
      s_overflow |=> stat_q[0] ##1 stat_q[0] || $past(stat_wr))
      else $error("overflow did not raise interrupt");
   no_tick_idle_a: assert property (
      (!run || STOP_MODE) |=> cnt_q == $past(cnt_q))
      else $error("counter ticks while stopped");
   reset_pin_a: assert property (@(posedge REF_CLK) disable iff (1'b0)
      SYS_RST |=> PULSE_OUT_PIN == 1'b1)
      else $error("reset did not clear flop");
   stop_freeze_a: assert property (
      !run && !ctrl_wr |=> $stable(PULSE_OUT_PIN))
      else $error("pin moved while stopped");
   run_hold_a: assert property (
      run && duty_wr && !ovf |=> $stable(duty_compare_reg_q))
      else $error("duty applied before period end");
   stop_load_a: assert property (
      !run && duty_wr |=> duty_compare_reg_q == $past(w_data_q))
      else $error("duty not applied while stopped");
   duty_read_a: assert property (
      rd_fire && S_AXI_ARADDR == pwm_pkg::OFS_DUTY |=>
         rdata_q[7:0] == $past(duty_hold_q))
      else $error("duty read not from holding stage");
   preset_a: assert property (
      ctrl_wr && !run |=> PULSE_OUT_PIN == !$past(w_data_q[7]))
      else $error("preset not applied");
   irq_out_a: assert property (
      |(stat_q & mask_q) |-> PERIOD_IRQ)
      else $error("interrupt output missing");
endmodule : pwm_timer_out
`default_nettype wire

// >>> include/pwm_pkg.sv
// Function
// - Counter and compare are 8 bits; period is 256 source ticks.
// - Counter advances on the selected divided main, main or sub tick.
// - Counter equal to active compare inverts the flop unless compare is 8'hFF (it meets overflow and the flop holds); counting continues.
// - Overflow inverts the flop again and clears the counter.
// - Overflow raises the period interrupt.
// - A control bit presets the flop for either pulse polarity.
// - Reset clears the flop to zero.
// - Output pin is always the inverse of the flop.
// - Duty write while running is held until the next period interrupt.
// - Duty write while stopped reaches the compare register at once.
// - Duty reads return the held value, not the active compare.
// - Stopping freezes the output pin level.
// - Clearing bit 3 stops; clearing bit 7 afterwards drives pin high.
// - Stop the timer before entering the stop power mode.
`default_nettype none
package pwm_pkg;
   localparam int          CNT_W       = 8;
   localparam int          ADDR_W      = 12;
   localparam int          DIV_W       = 11;
   localparam logic [11:0] OFS_CTRL    = 12'h000;
   localparam logic [11:0] OFS_DUTY    = 12'h004;
   localparam logic [11:0] OFS_STAT    = 12'h008;
   localparam logic [11:0] OFS_MASK    = 12'h00C;
   localparam logic [11:0] OFS_COUNT   = 12'h010;
   localparam int          TAP_BIT     = 0;
   localparam int          RUN_BIT     = 3;
   localparam int          SRC_LSB     = 4;
   localparam int          SRC_MSB     = 6;
   localparam int          PRESET_BIT  = 7;
   localparam int          IRQ_BIT     = 0;
   localparam logic [7:0]  CTRL_RST    = 8'h00;
   localparam logic [7:0]  DUTY_RST    = 8'h00;
   localparam logic [7:0]  CNT_MAX     = 8'hFF;
   localparam logic [2:0]  SUB_DIV_MAX = 3'h7;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      SRC_DIV2K = 3'h0,
      SRC_DIV128 = 3'h1,
      SRC_DIV32 = 3'h2,
      SRC_DIV8 = 3'h3,
      SRC_SUB = 3'h4,
      SRC_DIV2 = 3'h5,
      SRC_MAIN = 3'h6,
      SRC_NONE = 3'h7
   } pwm_src_e;
endpackage : pwm_pkg
`default_nettype wire

// >>> testbench/pwm_timer_out_bench.sv
`default_nettype none
module pwm_timer_out_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        REF_CLK = 1'b0;
   logic        SYS_RST, STOP_MODE;
   logic        SUB_OSC_CLK = 1'b0;
   logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
   logic [3:0]  S_AXI_WSTRB;
   logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
   logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
   logic        S_AXI_RVALID, S_AXI_RREADY, PULSE_OUT_PIN, PERIOD_IRQ;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
   logic [1:0]  sub_cnt   = 2'h0;
   logic [31:0] rd;
   int          error_cnt = 0;
   int          n_tests   = 0;
   int          len;

   pwm_timer_out u_pwm_timer_out (
      .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SUB_OSC_CLK(SUB_OSC_CLK),
      .STOP_MODE(STOP_MODE), .S_AXI_AWADDR(S_AXI_AWADDR),
      .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
      .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
      .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
      .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
      .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
      .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
      .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
      .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
      .PULSE_OUT_PIN(PULSE_OUT_PIN), .PERIOD_IRQ(PERIOD_IRQ));

   always #12.5 REF_CLK = ~REF_CLK;

   // Sub clock, one rising edge every 4 cycles
   always @(posedge REF_CLK) begin
      sub_cnt     <= sub_cnt + 2'h1;
      SUB_OSC_CLK <= sub_cnt[1];
   end

////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("Checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   task automatic hang(input string nm);
      error_cnt++;
      $display("BAD %s expected answer seen none", nm);
      results();
   endtask : hang

   task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
      logic fa, fw, fb;
      int   i;
      @(posedge REF_CLK);
      S_AXI_AWADDR  <= a;
      S_AXI_WDATA   <= {24'h000000, d};
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID  <= 1'b1;
      S_AXI_BREADY  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(negedge REF_CLK);
         fa  = S_AXI_AWREADY === 1'b1;
         fw  = S_AXI_WREADY === 1'b1;
         fb  = S_AXI_BVALID === 1'b1;
         rsp = S_AXI_BRESP;
         @(posedge REF_CLK);
         if (fa) S_AXI_AWVALID <= 1'b0;
         if (fw) S_AXI_WVALID <= 1'b0;
         if (fb) begin
            S_AXI_BREADY <= 1'b0;
            break;
         end
      end
      if (i == 50) hang("write");
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a);
      logic fa, fb;
      int   i;
      @(posedge REF_CLK);
      S_AXI_ARADDR  <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY  <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(negedge REF_CLK);
         fa  = S_AXI_ARREADY === 1'b1;
         fb  = S_AXI_RVALID === 1'b1;
         rd  = S_AXI_RDATA;
         rsp = S_AXI_RRESP;
         @(posedge REF_CLK);
         if (fa) S_AXI_ARVALID <= 1'b0;
         if (fb) begin
            S_AXI_RREADY <= 1'b0;
            break;
         end
      end
      if (i == 50) hang("read");
   endtask : axi_rd

   // Length of the next whole pulse at level lvl
   task automatic pulse_len(input logic lvl);
      int i;
      for (i = 0; i < 4000 && PULSE_OUT_PIN === lvl; i++) @(negedge REF_CLK);
      if (i >= 4000) hang("pulse");
      for (i = 0; i < 4000 && PULSE_OUT_PIN !== lvl; i++) @(negedge REF_CLK);
      for (len = 0; len < 4000 && PULSE_OUT_PIN === lvl; len++)
         @(negedge REF_CLK);
      if (len >= 4000 || i >= 4000) hang("pulse");
   endtask : pulse_len

////////////////////////////////////////////////////////////////////////////////
   task automatic t_stopped();
      axi_rd(pwm_pkg::OFS_CTRL);
      chk("ctrl reset", pwm_pkg::CTRL_RST, rd);
      axi_wr(pwm_pkg::OFS_DUTY, 8'h10);
      axi_rd(pwm_pkg::OFS_DUTY);
      chk("duty stopped", 8'h10, rd);
      axi_wr(pwm_pkg::OFS_CTRL, 8'h80);
      @(negedge REF_CLK);
      chk("preset pin", 1'b0, PULSE_OUT_PIN);
      axi_wr(pwm_pkg::OFS_CTRL, 8'h00);
   endtask : t_stopped

   task automatic t_sources();
      logic [2:0] src [4] = '{pwm_pkg::SRC_MAIN, pwm_pkg::SRC_DIV2,
                              pwm_pkg::SRC_SUB, pwm_pkg::SRC_DIV8};
      int         dv  [4] = '{1, 2, 4, 8};
      for (int k = 0; k < 4; k++) begin
         axi_wr(pwm_pkg::OFS_CTRL, {1'b0, src[k], 4'h8});
         pulse_len(1'b1);
         chk("high time", 17 * dv[k], len);
         pulse_len(1'b0);
         chk("low time", 239 * dv[k], len);
         axi_wr(pwm_pkg::OFS_CTRL, 8'h00);
      end
   endtask : t_sources

   task automatic t_irq_duty();
      int i;
      axi_wr(pwm_pkg::OFS_MASK, 8'h01);
      axi_wr(pwm_pkg::OFS_STAT, 8'h01);
      axi_wr(pwm_pkg::OFS_CTRL, 8'h68);
      for (i = 0; i < 600 && PERIOD_IRQ !== 1'b1; i++) @(negedge REF_CLK);
      if (i == 600) hang("interrupt");
      chk("pin at irq", 1'b1, PULSE_OUT_PIN);
      axi_wr(pwm_pkg::OFS_DUTY, 8'h80);
      axi_rd(pwm_pkg::OFS_DUTY);
      chk("duty held read", 8'h80, rd);
      pulse_len(1'b0);
      chk("old duty low", 239, len);
      pulse_len(1'b0);
      chk("new duty low", 127, len);
      axi_wr(pwm_pkg::OFS_MASK, 8'h00);
      @(negedge REF_CLK);
      chk("irq masked", 1'b0, PERIOD_IRQ);
      axi_wr(pwm_pkg::OFS_MASK, 8'h01);
      @(negedge REF_CLK);
      chk("irq unmasked", 1'b1, PERIOD_IRQ);
      axi_wr(pwm_pkg::OFS_STAT, 8'h01);
      @(negedge REF_CLK);
      chk("irq cleared", 1'b0, PERIOD_IRQ);
   endtask : t_irq_duty

   task automatic t_stop();
      int n = 0;
      pulse_len(1'b1);
      axi_wr(pwm_pkg::OFS_CTRL, 8'h60);
      repeat (300) begin
         @(negedge REF_CLK);
         if (PULSE_OUT_PIN !== 1'b0) n++;
      end
      chk("frozen pin", 0, n);
      axi_wr(pwm_pkg::OFS_CTRL, 8'h00);
      @(negedge REF_CLK);
      chk("pin forced high", 1'b1, PULSE_OUT_PIN);
      axi_rd(12'h7FC);
      chk("unmapped resp", pwm_pkg::RESP_SLVERR, rsp);
      axi_wr(pwm_pkg::OFS_COUNT, 8'h55);
      chk("count write resp", pwm_pkg::RESP_SLVERR, rsp);
   endtask : t_stop

   task automatic t_strb_sleep();
      logic [31:0] c0;
      @(posedge REF_CLK);
      S_AXI_WSTRB <= 4'h0;
      axi_wr(pwm_pkg::OFS_DUTY, 8'h33);
      chk("strb resp", pwm_pkg::RESP_OKAY, rsp);
      axi_rd(pwm_pkg::OFS_DUTY);
      chk("strb ignored", 8'h80, rd);
      S_AXI_WSTRB <= 4'hF;
      axi_wr(pwm_pkg::OFS_CTRL, 8'h68);
      STOP_MODE <= 1'b1;
      axi_rd(pwm_pkg::OFS_COUNT);
      c0 = rd;
      repeat (20) @(posedge REF_CLK);
      axi_rd(pwm_pkg::OFS_COUNT);
      chk("count in stop mode", c0, rd);
      STOP_MODE <= 1'b0;
      axi_rd(pwm_pkg::OFS_COUNT);
      chk("count resumes", {24'h000000, c0[7:0] + 8'h01}, rd);
      axi_wr(pwm_pkg::OFS_CTRL, 8'h00);
   endtask : t_strb_sleep

////////////////////////////////////////////////////////////////////////////////
   initial begin
      SYS_RST = 1'b1;
      {STOP_MODE, S_AXI_AWADDR, S_AXI_ARADDR} = '0;
      {S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = '0;
      {S_AXI_ARVALID, S_AXI_RREADY} = 2'h0;
      S_AXI_WSTRB = 4'hF;
      repeat (8) @(posedge REF_CLK);
      SYS_RST <= 1'b0;
      @(negedge REF_CLK);
      chk("pin after reset", 1'b1, PULSE_OUT_PIN);
      chk("irq after reset", 1'b0, PERIOD_IRQ);
      t_stopped();
      t_sources();
      t_irq_duty();
      t_stop();
      t_strb_sleep();
      results();
   end
endmodule : pwm_timer_out_bench
`default_nettype wire
